// File: common/ddr_io_regs.svh
`ifndef DDR_IO_REGS_SVH
`define DDR_IO_REGS_SVH

// Last bit index of a word for each gearbox mode.
`define GB_LAST_BY7 3'h6
`define GB_LAST_BY8 3'h7
`define GB_LAST_BY4 3'h3

// Reset values.
`define OE_RESET   1'b0
`define POL_RESET  1'b0
`define CNT_RESET  3'h0
`define WORD_RESET 8'h00

// Fixed gearbox width.
`define GB_WIDTH_FIXED 8

// Clock cycles from a word's completion to its valid pulse, with margin.
`define GB_WORD_LATENCY 5

`endif

// File: common/ddr_io_pkg.sv
package ddr_io_pkg;

	typedef enum logic [1:0] {
		GEAR_BY7,
		GEAR_BY8,
		GEAR_BY4X2
	} gear_mode_e;

	typedef enum logic [1:0] {
		DET_IDLE,
		DET_PREAMBLE,
		DET_EDGE
	} det_state_e;

	typedef struct packed {
		logic rise;
		logic fall;
	} ddr_rd_s;

	typedef struct packed {
		logic       valid;
		logic [7:0] word;
	} gear_out_s;

	typedef struct packed {
		logic       strobe_p1;
		logic       strobe_p2;
		det_state_e det;
		logic       pol;
		logic       rise_p1;
		logic       rise_p2;
		logic       fall_p1;
		logic       fall_p2;
		ddr_rd_s    rd;
		logic       oe_sdr;
		logic       ddr_en;
		logic       req1;
		logic       req2;
		logic       ack;
		gear_out_s  gear;
		logic       align_tog;
	} sys_state_s;

	typedef struct packed {
		logic       rst1;
		logic       rst2;
		logic       al1;
		logic       al2;
		logic       al3;
		logic       ack1;
		logic       ack2;
		logic [2:0] cnt;
		logic [7:0] sh;
		logic [7:0] hold;
		logic       req;
	} fast_state_s;

endpackage

// File: logic/ddr_io_capture_and_gearbox.sv
`timescale 1ns/1ps
`include "ddr_io_regs.svh"
// Overview of operation
// R1: The block offers a DDR memory capture mode beside its plain modes.
// R2: DDR data is caught on both edges of the read strobe as two streams.
// R3: Both streams are moved into the system clock domain side by side.
// R4: The polarity control picks the clock edge of the transfer registers.
// R5: Strobe and polarity come from the block's own strobe logic, not core.
// R6: The SDR output enable passes one system clock flip-flop to the pad.
// R7: In DDR mode the enable passes a register on the write strobe to the pad.
// R8: The gearbox deserializes 1:7, 1:8 or as two independent 1:4 halves.
// R9: 1:7 uses bits 6..0, 1:8 bits 7..0, the 1:4 halves 7..4 and 3..0.
// R10: Core drives word alignment; serial in on fast clock, words on clock.
// R11: Polarity is found from the first strobe rise after the low preamble.
// R12: Each alignment pulse slips the word boundary by one serial bit.
module ddr_io_capture_and_gearbox
#(
	parameter int GB_WIDTH = 8
) (
	// System side.
	input  wire logic                   clock,
	input  wire logic                   rstn,
	// Strobes and edge clock.
	input  wire logic                   read_strobe_shifted,
	input  wire logic                   write_strobe_shifted,
	input  wire logic                   fast_edge_clock,
	// Capture configuration and read path.
	input  wire logic                   ddr_mem_mode,
	input  wire logic                   read_start,
	input  wire logic                   data_pad_in,
	output      ddr_io_pkg::ddr_rd_s    rd_data,
	output      logic                   sync_clock_polarity,
	// Tri-state path.
	input  wire logic                   sdr_enable_in,
	input  wire logic                   ddr_enable_in,
	output      logic                   pad_oe,
	// Input gearbox.
	input  wire ddr_io_pkg::gear_mode_e gear_mode,
	input  wire logic                   serial_in_a,
	input  wire logic                   serial_in_c,
	input  wire logic                   word_align_pulse,
	output      ddr_io_pkg::gear_out_s  gear_out
);
	import ddr_io_pkg::*;

	if (GB_WIDTH != `GB_WIDTH_FIXED) begin : g_chk
		$error("GB_WIDTH must be 8");
	end

	sys_state_s  s_r;
	sys_state_s  s_nxt;
	fast_state_s f_r;
	fast_state_s f_nxt;

	// Capture registers on the read strobe edges.
	logic rs_pos_r;
	logic rs_neg_r;

	// Transfer registers on the falling system clock edge.
	logic sn1_r;
	logic sn2_r;
	logic rn1_r;
	logic rn2_r;
	logic fn1_r;
	logic fn2_r;
	logic sn3_r;

	// Write strobe domain.
	logic wrst1_r;
	logic wrst2_r;
	logic we1_r;
	logic we2_r;
	logic oe_ddr_r;

	always_ff @(posedge read_strobe_shifted) begin // R2
		rs_pos_r <= data_pad_in;
	end

	always_ff @(negedge read_strobe_shifted) begin // R2
		rs_neg_r <= data_pad_in;
	end

	// The falling edge path serves the inverted polarity choice.
	always_ff @(negedge clock) begin // R4
		if (!rstn) begin
			sn1_r <= 1'b0;
			sn2_r <= 1'b0;
			sn3_r <= 1'b0;
			rn1_r <= 1'b0;
			rn2_r <= 1'b0;
			fn1_r <= 1'b0;
			fn2_r <= 1'b0;
		end else begin
			sn1_r <= read_strobe_shifted;
			sn2_r <= sn1_r;
			sn3_r <= sn2_r;
			rn1_r <= rs_pos_r;
			rn2_r <= rn1_r;
			fn1_r <= rs_neg_r;
			fn2_r <= fn1_r;
		end
	end

	always_comb begin
		s_nxt = s_r;
		s_nxt.strobe_p1 = read_strobe_shifted;
		s_nxt.strobe_p2 = s_r.strobe_p1;
		s_nxt.rise_p1 = rs_pos_r;
		s_nxt.rise_p2 = s_r.rise_p1;
		s_nxt.fall_p1 = rs_neg_r;
		s_nxt.fall_p2 = s_r.fall_p1;
		case (s_r.det) // R11 R5
		DET_IDLE: begin
			if (read_start) begin
				s_nxt.det = DET_PREAMBLE;
			end
		end
		DET_PREAMBLE: begin
			if (!s_r.strobe_p2) begin
				s_nxt.det = DET_EDGE;
			end
		end
		DET_EDGE: begin
			if (s_r.strobe_p2) begin
				// The deeper falling edge sample is high only if the rise
				// came in the clock's high half: then use the falling edge.
				s_nxt.pol = sn3_r;
				s_nxt.det = DET_IDLE;
			end
		end
		default: begin
			s_nxt.det = DET_IDLE;
		end
		endcase
		if (ddr_mem_mode) begin // R1 R3 R4
			s_nxt.rd.rise = s_r.pol ? rn2_r : s_r.rise_p2;
			s_nxt.rd.fall = s_r.pol ? fn2_r : s_r.fall_p2;
		end else begin
			s_nxt.rd = '0;
		end
		s_nxt.oe_sdr = sdr_enable_in; // R6
		s_nxt.ddr_en = ddr_enable_in;
		s_nxt.req1 = f_r.req;
		s_nxt.req2 = s_r.req1;
		s_nxt.gear.valid = 1'b0;
		if (s_r.req2 != s_r.ack) begin // R10
			s_nxt.gear.word = f_r.hold;
			s_nxt.gear.valid = 1'b1;
			s_nxt.ack = s_r.req2;
		end
		if (word_align_pulse) begin
			s_nxt.align_tog = !s_r.align_tog;
		end
		if (!rstn) begin
			s_nxt = '0;
			s_nxt.det = DET_IDLE;
			s_nxt.pol = `POL_RESET;
			s_nxt.oe_sdr = `OE_RESET;
			s_nxt.gear.word = `WORD_RESET;
		end
	end

	always_ff @(posedge clock) begin
		s_r <= s_nxt;
	end

	always_ff @(posedge write_strobe_shifted) begin // R7
		wrst1_r <= rstn;
		wrst2_r <= wrst1_r;
		we1_r <= s_r.ddr_en;
		we2_r <= we1_r;
		if (!wrst2_r) begin
			oe_ddr_r <= `OE_RESET;
		end else begin
			oe_ddr_r <= we2_r;
		end
	end

	logic [7:0] sh_n;
	logic [2:0] last;
	logic       slip;

	always_comb begin
		f_nxt = f_r;
		f_nxt.rst1 = rstn;
		f_nxt.rst2 = f_r.rst1;
		f_nxt.al1 = s_r.align_tog;
		f_nxt.al2 = f_r.al1;
		f_nxt.al3 = f_r.al2;
		f_nxt.ack1 = s_r.ack;
		f_nxt.ack2 = f_r.ack1;
		slip = f_r.al2 != f_r.al3;
		case (gear_mode) // R8 R9
		GEAR_BY7: begin
			last = `GB_LAST_BY7;
			sh_n = {serial_in_a, f_r.sh[7:1]};
		end
		GEAR_BY8: begin
			last = `GB_LAST_BY8;
			sh_n = {serial_in_a, f_r.sh[7:1]};
		end
		GEAR_BY4X2: begin
			last = `GB_LAST_BY4;
			sh_n = {serial_in_a, f_r.sh[7:5], serial_in_c, f_r.sh[3:1]};
		end
		default: begin
			last = `GB_LAST_BY8;
			sh_n = f_r.sh;
		end
		endcase
		f_nxt.sh = sh_n;
		if (slip) begin // R12
			f_nxt.cnt = f_r.cnt;
		end else if (f_r.cnt >= last) begin
			f_nxt.cnt = `CNT_RESET;
			// A word that finds the previous one still unclaimed is dropped.
			if (f_r.ack2 == f_r.req) begin // R10
				f_nxt.hold = (gear_mode == GEAR_BY7) ?
					{1'b0, sh_n[7:1]} : sh_n;
				f_nxt.req = !f_r.req;
			end
		end else begin
			f_nxt.cnt = f_r.cnt + 3'h1;
		end
		if (!f_r.rst2) begin
			f_nxt.cnt = `CNT_RESET;
			f_nxt.sh = `WORD_RESET;
			f_nxt.hold = `WORD_RESET;
			f_nxt.req = 1'b0;
			f_nxt.al2 = 1'b0;
			f_nxt.al3 = 1'b0;
			f_nxt.ack2 = 1'b0;
		end
	end

	always_ff @(posedge fast_edge_clock) begin
		f_r <= f_nxt;
	end

	assign rd_data = s_r.rd;
	assign sync_clock_polarity = s_r.pol;
	assign gear_out = s_r.gear;
	assign pad_oe = ddr_mem_mode ? oe_ddr_r : s_r.oe_sdr; // R6 R7

	property p_sdr_oe;
		@(posedge clock) disable iff (!rstn)
		(!ddr_mem_mode && $past(rstn)) |-> pad_oe == $past(sdr_enable_in);
	endproperty
	a_sdr_oe: assert property (p_sdr_oe) // R6
		else $error("SDR enable not passed through one flip-flop");

	property p_ddr_oe;
		@(posedge write_strobe_shifted) disable iff (!wrst2_r)
		ddr_mem_mode ##1 ddr_mem_mode |-> pad_oe == $past(we2_r);
	endproperty
	a_ddr_oe: assert property (p_ddr_oe) // R7
		else $error("DDR enable not taken from the write strobe register");

	property p_pos_sync;
		@(posedge clock) disable iff (!rstn)
		(ddr_mem_mode && !s_r.pol) |=> rd_data.rise == $past(s_r.rise_p2);
	endproperty
	a_pos_sync: assert property (p_pos_sync) // R3
		else $error("Rising stream not taken from rising edge sync");

	property p_neg_sync;
		@(posedge clock) disable iff (!rstn)
		(ddr_mem_mode && s_r.pol) |=> rd_data.fall == $past(fn2_r);
	endproperty
	a_neg_sync: assert property (p_neg_sync) // R4
		else $error("Falling stream not taken from falling edge sync");

	property p_mode_off;
		@(posedge clock) disable iff (!rstn)
		!ddr_mem_mode |=> rd_data == '0;
	endproperty
	a_mode_off: assert property (p_mode_off) // R1
		else $error("Streams active outside DDR memory mode");

	property p_pol_hold;
		@(posedge clock) disable iff (!rstn)
		(s_r.det != DET_EDGE) |=> $stable(sync_clock_polarity);
	endproperty
	a_pol_hold: assert property (p_pol_hold) // R11
		else $error("Polarity changed outside the first strobe rise");

	property p_by7_lane;
		@(posedge clock) disable iff (!rstn)
		(gear_out.valid && gear_mode == GEAR_BY7 &&
			$past(gear_mode, `GB_WORD_LATENCY) == GEAR_BY7)
			|-> gear_out.word[7] == 1'b0;
	endproperty
	a_by7_lane: assert property (p_by7_lane) // R9
		else $error("Bit 7 set in 1:7 mode");

	property p_cnt_wrap;
		@(posedge fast_edge_clock) disable iff (!f_r.rst2)
		(gear_mode == GEAR_BY4X2 && f_r.cnt == `GB_LAST_BY4 && !slip)
			|=> f_r.cnt == `CNT_RESET;
	endproperty
	a_cnt_wrap: assert property (p_cnt_wrap) // R8
		else $error("1:4 word counter did not wrap after four bits");

	property p_slip;
		@(posedge fast_edge_clock) disable iff (!f_r.rst2)
		slip |=> f_r.cnt == $past(f_r.cnt);
	endproperty
	a_slip: assert property (p_slip) // R12
		else $error("Alignment pulse did not hold the bit counter");

	property p_valid_pulse;
		@(posedge clock) disable iff (!rstn)
		gear_out.valid |=> !gear_out.valid;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) // R10
		else $error("Word valid held longer than one cycle");

endmodule

// File: sim/ddr_mem_model.sv
`timescale 1ns/1ps
module ddr_mem_model (
	// Memory side of the data pin.
	output logic strobe,
	output logic dq
);
	// Idle strobe sits at the termination level.
	initial begin
		strobe = 1'b1;
		dq     = 1'b1;
	end

	// One read burst: preamble, then four bit pairs, rise bit first.
	task automatic burst(input int skew, input logic [3:0] r,
		input logic [3:0] f);
		#(skew);
		strobe = 1'b0;
		#400;
		for (int i = 0; i < 4; i++) begin
			dq = r[i];
			#200 strobe = 1'b1;
			#200 dq = f[i];
			#200 strobe = 1'b0;
			#200;
		end
		// The released data line shows the inverse of its last value.
		dq = ~dq;
		#200 strobe = 1'b1;
	endtask
endmodule

// File: sim/ddr_io_capture_and_gearbox_test.sv
`timescale 1ns/1ps
module ddr_io_capture_and_gearbox_test;
	import ddr_io_pkg::*;
	logic       clock = 1'b0, rstn = 1'b0, wstb = 1'b0, fclk = 1'b0;
	logic       ddr_mem_mode = 1'b0, read_start = 1'b0;
	logic       sdr_enable_in = 1'b0, ddr_enable_in = 1'b0;
	logic       serial_in_a = 1'b0, serial_in_c = 1'b0, align = 1'b0;
	logic       strobe, dq, pol, pad_oe;
	logic [7:0] pat_a = 8'hB4, pat_c = 8'h00;
	int         len = 8, bi = 0, num_errors = 0, num_checks = 0;
	gear_mode_e gear_mode = GEAR_BY8;
	ddr_rd_s    rd_data;
	gear_out_s  gear_out;

	always #50 clock = ~clock;
	always #24 fclk = ~fclk;
	always #32 wstb = ~wstb;
	always @(posedge fclk) begin
		#5;
		serial_in_a = pat_a[bi];
		serial_in_c = pat_c[bi];
		bi = (bi + 1) % len;
	end

	ddr_mem_model ddr_mem_model_i (
		.strobe (strobe),
		.dq     (dq)
	);

	ddr_io_capture_and_gearbox #(.GB_WIDTH(8)) ddr_io_capture_and_gearbox_i (
		.clock                (clock),
		.rstn                 (rstn),
		.read_strobe_shifted  (strobe),
		.write_strobe_shifted (wstb),
		.fast_edge_clock      (fclk),
		.ddr_mem_mode         (ddr_mem_mode),
		.read_start           (read_start),
		.data_pad_in          (dq),
		.rd_data              (rd_data),
		.sync_clock_polarity  (pol),
		.sdr_enable_in        (sdr_enable_in),
		.ddr_enable_in        (ddr_enable_in),
		.pad_oe               (pad_oe),
		.gear_mode            (gear_mode),
		.serial_in_a          (serial_in_a),
		.serial_in_c          (serial_in_c),
		.word_align_pulse     (align),
		.gear_out             (gear_out)
	);

	task automatic tick();
		@(posedge clock);
		#5;
	endtask

	task automatic chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			num_errors++;
			$display("mismatch at %0t: %s", $time, m);
		end
	endtask

	function automatic logic is_rot(logic [7:0] w, logic [7:0] p, int n);
		logic       hit;
		logic [7:0] q, m;
		m = ~(8'hFF << n);
		hit = 1'b0;
		q = p & m;
		for (int k = 0; k < n; k++) begin
			hit |= (((w ^ q) & m) === 8'h00);
			q = ((q >> 1) | (q << (n - 1))) & m;
		end
		return hit;
	endfunction

	task automatic wait_word(output logic [7:0] w);
		w = 8'hXX;
		for (int k = 0; k < 300; k++) begin
			tick();
			if (gear_out.valid === 1'b1) begin
				w = gear_out.word;
				return;
			end
		end
		chk(1'b0, "no gearbox word");
	endtask

	task automatic t_sdr_oe();
		sdr_enable_in = 1'b1;
		tick();
		chk(pad_oe === 1'b1, "sdr enable");
		sdr_enable_in = 1'b0;
		ddr_enable_in = 1'b1;
		tick();
		chk(pad_oe === 1'b0, "sdr disable");
	endtask

	task automatic t_ddr_oe();
		ddr_enable_in = 1'b0;
		ddr_mem_mode = 1'b1;
		repeat (10) tick();
		chk(pad_oe === 1'b0, "ddr idle");
		ddr_enable_in = 1'b1;
		tick();
		chk(pad_oe === 1'b0, "ddr enable too early");
		for (int k = 0; k < 20 && pad_oe !== 1'b1; k++) tick();
		chk(pad_oe === 1'b1, "ddr enable");
		ddr_enable_in = 1'b0;
	endtask

	// Strobe is slow against the clock, so each sample stands for a while.
	// The first strobe fall opens the preamble; each later fall ends a pair.
	task automatic t_read(input int skew, input logic pol_exp);
		logic [3:0] rv, fv;
		rv = 4'h5;
		fv = 4'hC;
		read_start = 1'b1;
		tick();
		read_start = 1'b0;
		fork
			ddr_mem_model_i.burst(skew, rv, fv);
			begin
				@(negedge strobe);
				for (int i = 0; i < 4; i++) begin
					@(negedge strobe);
					repeat (5) tick();
					chk(rd_data.rise === rv[i], "rise stream");
					chk(rd_data.fall === fv[i], "fall stream");
				end
			end
		join
		chk(pol === pol_exp, "sync clock polarity");
		ddr_mem_mode = 1'b0;
		repeat (2) tick();
		chk(rd_data === 2'b00, "plain mode read");
		ddr_mem_mode = 1'b1;
	endtask

	task automatic t_gear(input gear_mode_e m, input int n,
		input logic [7:0] a, input logic [7:0] c);
		logic [7:0] w;
		gear_mode = m;
		len = n;
		pat_a = a;
		pat_c = c;
		repeat (2) wait_word(w);
		repeat (3) begin
			wait_word(w);
			if (m == GEAR_BY4X2) begin
				chk(is_rot(w[7:4], a, 4) && is_rot(w[3:0], c, 4), "x4");
			end else begin
				chk(is_rot(w, a, n) && (n == 8 || w[7] === 1'b0), "wd");
			end
		end
	endtask

	task automatic t_align();
		logic [7:0] w0, w1;
		wait_word(w0);
		align = 1'b1;
		tick();
		align = 1'b0;
		repeat (20) tick();
		wait_word(w1);
		chk(w1 === {w0[0], w0[7:1]}, "word slip");
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		#500000;
		num_errors++;
		test_done();
	end

	initial begin
		repeat (4) tick();
		rstn = 1'b1;
		repeat (2) tick();
		t_sdr_oe();
		t_ddr_oe();
		t_read(0, 1'b1);
		t_read(60, 1'b0);
		t_gear(GEAR_BY7, 7, 8'h4D, 8'h00);
		t_gear(GEAR_BY4X2, 4, 8'h0D, 8'h03);
		t_gear(GEAR_BY8, 8, 8'hB4, 8'h00);
		t_align();
		test_done();
	end
endmodule
